// >>> rtl/sfph_protect_hold.sv
`timescale 1ns/1ps
`default_nettype none
module sfph_protect_hold
  import sfph_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_o,
  output logic so_oe,
  input wire logic quad_enable,
  input wire logic factory_otp_locked,
  input wire logic op_busy,
  output sfph_op_s op_req,
  output logic [3:0] protect_level,
  output logic top_bottom_select,
  output logic status_write_lock,
  output logic write_latch,
  output logic otp_mode,
  output logic customer_otp_locked,
  output logic [3:0] protected_blocks,
  output logic array_blocked,
  output logic link_active
);

  // Link state on rising serial clock, cleared while chip select is high
  typedef struct packed {
    sfph_link_e st;
    logic [2:0] bitcnt;
    logic [6:0] shift;
    logic [2:0] nbytes;
  } sfph_lk_s;

  // Link state on falling serial clock: pause, output shifter, crossings
  typedef struct packed {
    logic pause;
    logic drive;
    logic [7:0] tx;
    logic [7:0] stat_s1;
    logic [7:0] stat_s2;
    logic [7:0] sec_s1;
    logic [7:0] sec_s2;
    logic quad_s1;
    logic quad_s2;
  } sfph_ln_s;

  // Core domain state
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic wp_s1;
    logic wp_s2;
    logic fact_s1;
    logic fact_s2;
    logic [3:0] bp;
    logic top_sel;
    logic swl;
    logic wl;
    logic otp;
    logic cust;
    logic [7:0] stat;
    logic [7:0] sec;
    sfph_op_s op;
  } sfph_core_s;

  sfph_lk_s lk_q, lk_d;
  sfph_ln_s ln_q, ln_d;
  sfph_rec_s rec_q, rec_d;
  sfph_core_s cr_q, cr_d;

  logic byte_done;
  logic [7:0] byte_in;
  logic lk_rst;
  logic cs_rise;
  logic hw_prot;
  logic [3:0] prot_now;
  logic blk_prot;
  logic may_write;

  assign lk_rst = !reset_n || cs_n;
  assign byte_in = {lk_q.shift, si};
  assign byte_done = (lk_q.bitcnt == 3'h7) && !ln_q.pause;

  // Rising edge: shift in, count bits and bytes, classify the opcode
  always_comb begin
    lk_d = lk_q;
    if (!ln_q.pause && lk_q.st != LK_STANDBY) begin
      lk_d.shift = byte_in[6:0];
      lk_d.bitcnt = lk_q.bitcnt + 3'h1;
      if (byte_done) begin
        if (lk_q.nbytes != 3'h7) begin
          lk_d.nbytes = lk_q.nbytes + 3'h1;
        end
        if (lk_q.st == LK_CMD) begin
          // Unknown opcode parks the link until the next frame
          lk_d.st = sfph_known(byte_in) ? LK_ACTIVE : LK_STANDBY;
        end
      end
    end
  end

  // Protocol reset by chip select high, also during a pause
  always_ff @(posedge sclk or posedge lk_rst) begin
    if (lk_rst) begin
      lk_q <= '{st: LK_CMD, bitcnt: 3'h0, shift: 7'h00, nbytes: 3'h0};
    end else begin
      lk_q <= lk_d;
    end
  end

  // Frame record survives chip select so the core can read it afterwards
  always_comb begin
    rec_d = rec_q;
    if (!cs_n && !ln_q.pause && lk_q.st != LK_STANDBY) begin
      if (lk_q.bitcnt == 3'h0 && lk_q.nbytes == 3'h0) begin
        rec_d.nbytes = 3'h0;
        rec_d.opcode = 8'h00;
      end
      rec_d.boundary = byte_done;
      if (byte_done) begin
        rec_d.nbytes = (lk_q.nbytes == 3'h7) ? 3'h7 : lk_q.nbytes + 3'h1;
        case (lk_q.nbytes)
          3'h0: begin
            rec_d.opcode = byte_in;
          end
          3'h1: begin
            rec_d.addr[23:16] = byte_in;
            rec_d.data0 = byte_in;
          end
          3'h2: begin
            rec_d.addr[15:8] = byte_in;
            rec_d.data1 = byte_in;
          end
          3'h3: begin
            rec_d.addr[7:0] = byte_in;
          end
          default: begin
            rec_d.data0 = rec_q.data0;
          end
        endcase
      end
    end else if (!cs_n && lk_q.st == LK_STANDBY) begin
      rec_d.opcode = 8'h00; // Discarded frame leaves no command behind
    end
  end

  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      rec_q <= '0;
    end else begin
      rec_q <= rec_d;
    end
  end

  // Falling edge: pause changes only with the clock low, output shifts
  always_comb begin
    ln_d = ln_q;
    ln_d.stat_s1 = cr_q.stat;
    ln_d.stat_s2 = ln_q.stat_s1;
    ln_d.sec_s1 = cr_q.sec;
    ln_d.sec_s2 = ln_q.sec_s1;
    ln_d.quad_s1 = quad_enable;
    ln_d.quad_s2 = ln_q.quad_s1;
    ln_d.pause = !ln_q.quad_s2 && !hold_n;
    if (!ln_q.pause) begin
      if (lk_q.bitcnt == 3'h0 && lk_q.nbytes != 3'h0 && lk_q.st == LK_ACTIVE &&
          (rec_q.opcode == OP_RDSR || rec_q.opcode == OP_SEC_RD)) begin
        // Status bytes repeat for as long as the host keeps clocking
        ln_d.tx = (rec_q.opcode == OP_RDSR) ? ln_q.stat_s2 : ln_q.sec_s2;
        ln_d.drive = 1'b1;
      end else begin
        ln_d.tx = {ln_q.tx[6:0], 1'b0};
      end
    end
  end

  always_ff @(negedge sclk or posedge lk_rst) begin
    if (lk_rst) begin
      ln_q <= '0;
    end else begin
      ln_q <= ln_d;
    end
  end

  // Output released in standby, during a pause and between frames
  assign so_o = ln_q.tx[7];
  assign so_oe = ln_q.drive && !ln_q.pause && lk_q.st == LK_ACTIVE && !cs_n;

  // Core decode helpers
  assign cs_rise = cr_q.cs_s2 && !cr_q.cs_s3;
  assign hw_prot = cr_q.swl && !cr_q.wp_s2 && !quad_enable;
  assign prot_now = sfph_prot_mask(cr_q.bp, cr_q.top_sel);
  assign blk_prot = prot_now[rec_q.addr[BLK_HI:BLK_LO]] || (rec_q.addr > ARRAY_TOP);
  assign may_write = cr_q.wl && !op_busy && rec_q.boundary;

  // Core: execute the captured frame once chip select has risen
  always_comb begin
    cr_d = cr_q;
    cr_d.cs_s1 = cs_n;
    cr_d.cs_s2 = cr_q.cs_s1;
    cr_d.cs_s3 = cr_q.cs_s2;
    cr_d.wp_s1 = wp_n;
    cr_d.wp_s2 = cr_q.wp_s1;
    cr_d.fact_s1 = factory_otp_locked;
    cr_d.fact_s2 = cr_q.fact_s1;
    cr_d.op = '{valid: 1'b0, kind: OPK_NONE, addr: 24'h000000};
    if (cs_rise) begin
      case (rec_q.opcode)
        OP_WR_EN: begin
          if (rec_q.boundary && rec_q.nbytes == 3'h1) begin
            cr_d.wl = 1'b1;
          end
        end
        OP_WRDI: begin
          if (rec_q.boundary && rec_q.nbytes == 3'h1) begin
            cr_d.wl = 1'b0;
          end
        end
        OP_WRSR: begin
          if (may_write && rec_q.nbytes >= 3'h2 && rec_q.nbytes <= 3'h3) begin
            if (!hw_prot) begin
              cr_d.bp = rec_q.data0[ST_BP_LO +: 4];
              cr_d.swl = rec_q.data0[ST_SWL];
              if (rec_q.nbytes == 3'h3) begin
                cr_d.top_sel = rec_q.data1[CF_TOP_SEL];
              end
            end
            cr_d.wl = 1'b0;
          end
        end
        OP_PP: begin
          if (may_write && rec_q.nbytes >= NB_PROG) begin
            cr_d.wl = 1'b0;
            if (cr_q.otp) begin
              // Lower half customer, upper half factory
              if (rec_q.addr[OTP_HALF_BIT] ? !cr_q.fact_s2 : !cr_q.cust) begin
                cr_d.op = '{valid: 1'b1, kind: OPK_OTP_PROG, addr: rec_q.addr};
              end
            end else if (!blk_prot) begin
              cr_d.op = '{valid: 1'b1, kind: OPK_PROG, addr: rec_q.addr};
            end
          end
        end
        OP_SE, OP_BE32, OP_BE: begin
          if (may_write && rec_q.nbytes == NB_ADDR) begin
            cr_d.wl = 1'b0;
            // The secured area cannot be erased at all
            if (!cr_q.otp && !blk_prot) begin
              cr_d.op.valid = 1'b1;
              cr_d.op.addr = rec_q.addr;
              cr_d.op.kind = (rec_q.opcode == OP_SE) ? OPK_SECT :
                             (rec_q.opcode == OP_BE32) ? OPK_B32 : OPK_B64;
            end
          end
        end
        OP_CE1, OP_CE2: begin
          if (may_write && rec_q.nbytes == 3'h1) begin
            cr_d.wl = 1'b0;
            if (cr_q.bp == BP_NONE && !cr_q.otp) begin
              cr_d.op = '{valid: 1'b1, kind: OPK_CHIP, addr: 24'h000000};
            end
          end
        end
        OP_OTP_ENTER: begin
          if (rec_q.boundary && rec_q.nbytes == 3'h1) begin
            cr_d.otp = 1'b1;
          end
        end
        OP_OTP_EXIT: begin
          if (rec_q.boundary && rec_q.nbytes == 3'h1) begin
            cr_d.otp = 1'b0;
          end
        end
        OP_SEC_WR: begin
          if (may_write && rec_q.nbytes == 3'h1) begin
            cr_d.cust = 1'b1;
            cr_d.wl = 1'b0;
          end
        end
        default: begin
          cr_d.wl = cr_q.wl; // Reads and unknown frames change nothing
        end
      endcase
    end
    // Status images presented to the link for read-out
    cr_d.stat = 8'h00;
    cr_d.stat[ST_BUSY] = op_busy;
    cr_d.stat[ST_WL] = cr_d.wl;
    cr_d.stat[ST_BP_LO +: 4] = cr_d.bp;
    cr_d.stat[ST_SWL] = cr_d.swl;
    cr_d.sec = 8'h00;
    cr_d.sec[SC_FACT] = cr_q.fact_s2;
    cr_d.sec[SC_CUST] = cr_d.cust;
  end

  // Chip select reset value is high so no false rise after reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cr_q <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, wp_s1: 1'b1, wp_s2: 1'b1,
                default: '0};
    end else begin
      cr_q <= cr_d;
    end
  end

  // Status outputs from core registers; array_blocked also follows op_busy directly
  assign op_req = cr_q.op;
  assign protect_level = cr_q.bp;
  assign top_bottom_select = cr_q.top_sel;
  assign status_write_lock = cr_q.swl;
  assign write_latch = cr_q.wl;
  assign otp_mode = cr_q.otp;
  assign customer_otp_locked = cr_q.cust;
  assign protected_blocks = prot_now;
  assign array_blocked = cr_q.otp || op_busy;
  assign link_active = !cr_q.cs_s2;

endmodule
`default_nettype wire

// >>> rtl/sfph_pkg.sv
package sfph_pkg;

  // Opcodes
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE = 8'hd8;
  localparam logic [7:0] OP_CE1 = 8'h60;
  localparam logic [7:0] OP_CE2 = 8'hc7;
  localparam logic [7:0] OP_OTP_ENTER = 8'hb1;
  localparam logic [7:0] OP_OTP_EXIT = 8'hc1;
  localparam logic [7:0] OP_SEC_RD = 8'h2b;
  localparam logic [7:0] OP_SEC_WR = 8'h2f;

  // Field positions in the status, config and security bytes
  localparam int ST_BUSY = 0;
  localparam int ST_WL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_SWL = 7;
  localparam int CF_TOP_SEL = 3;
  localparam int SC_FACT = 0;
  localparam int SC_CUST = 1;

  // Array map
  localparam int ADDR_W = 24;
  localparam int BLK_HI = 17;
  localparam int BLK_LO = 16;
  localparam logic [23:0] ARRAY_TOP = 24'h03ffff;
  localparam int OTP_HALF_BIT = 9;
  localparam logic [2:0] NB_ADDR = 3'h4;
  localparam logic [2:0] NB_PROG = 3'h5;
  localparam logic [3:0] BP_NONE = 4'h0;
  localparam logic [3:0] BP_ONE = 4'h1;
  localparam logic [3:0] BP_TWO = 4'h2;

  typedef enum logic [2:0] {
    LK_CMD = 3'b001,
    LK_ACTIVE = 3'b010,
    LK_STANDBY = 3'b100
  } sfph_link_e;

  typedef enum logic [3:0] {
    OPK_NONE = 4'h0,
    OPK_PROG = 4'h1,
    OPK_SECT = 4'h2,
    OPK_B32 = 4'h3,
    OPK_B64 = 4'h4,
    OPK_CHIP = 4'h5,
    OPK_OTP_PROG = 4'h6
  } sfph_opk_e;

  // Frame record handed from the link to the core
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] data0;
    logic [7:0] data1;
    logic [2:0] nbytes;
    logic boundary;
  } sfph_rec_s;

  // Operation request towards the program/erase engine
  typedef struct packed {
    logic valid;
    sfph_opk_e kind;
    logic [23:0] addr;
  } sfph_op_s;

  function automatic logic sfph_known(input logic [7:0] op);
    case (op)
      OP_WR_EN, OP_WRDI, OP_RDSR, OP_WRSR, OP_READ, OP_PP, OP_SE, OP_BE32,
      OP_BE, OP_CE1, OP_CE2, OP_OTP_ENTER, OP_OTP_EXIT, OP_SEC_RD, OP_SEC_WR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Which 64KB blocks a level and top select protect
  function automatic logic [3:0] sfph_prot_mask(input logic [3:0] bp, input logic top_sel);
    if (bp == BP_NONE) return 4'h0;
    else if (bp == BP_ONE) return top_sel ? 4'h1 : 4'h8;
    else if (bp == BP_TWO) return top_sel ? 4'h3 : 4'hc;
    else return 4'hf;
  endfunction

endpackage

// >>> bench/sfph_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sfph_asserts
  import sfph_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_oe,
  input wire logic quad_enable,
  input wire sfph_op_s op_req,
  input wire logic [3:0] protect_level,
  input wire logic top_bottom_select,
  input wire logic status_write_lock,
  input wire logic write_latch,
  input wire logic otp_mode,
  input wire logic customer_otp_locked,
  input wire logic [3:0] protected_blocks,
  input wire logic link_active
);
  // Reference block map, written apart from the core's decoder
  function automatic logic [3:0] blk_mask(input logic [3:0] l, input logic t);
    if (l == 4'h0) return 4'h0;
    if (l > 4'h2) return 4'hf;
    return (l == 4'h1) ? (t ? 4'h1 : 4'h8) : (t ? 4'h3 : 4'hc);
  endfunction
  // Select and hardware lock levels held long enough to pass the two-flop sync
  sequence sel_held;
    !cs_n [*4];
  endsequence
  sequence desel_held;
    cs_n [*4];
  endsequence
  sequence hw_locked;
    (status_write_lock && !wp_n && !quad_enable) [*4];
  endsequence
  // Core domain checks
  prot_map_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    protected_blocks == blk_mask(protect_level, top_bottom_select))
    else $error("protected block map wrong");
  chip_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    op_req.valid && op_req.kind == OPK_CHIP |-> protect_level == 4'h0)
    else $error("chip erase with nonzero level");
  cust_sticky_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    customer_otp_locked |=> customer_otp_locked) else $error("customer lock dropped");
  otp_split_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    op_req.valid |-> otp_mode == (op_req.kind == OPK_OTP_PROG))
    else $error("array request in secured mode");
  addr_range_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    op_req.valid && op_req.kind != OPK_CHIP |-> op_req.addr <= ARRAY_TOP)
    else $error("request beyond array");
  latch_need_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    op_req.valid |-> write_latch || $past(write_latch) || $past(write_latch, 2))
    else $error("request without write latch");
  link_on_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sel_held |-> link_active) else $error("link not active while selected");
  link_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    desel_held |-> !link_active && !so_oe) else $error("link busy while deselected");
  hw_lock_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    hw_locked |=> $stable(protect_level)) else $error("level changed under hw protect");
  // Link domain: a pause seen at one fall silences the output by the next
  pause_quiet_a: assert property (@(negedge sclk) disable iff (cs_n || !reset_n)
    !hold_n && !quad_enable |=> !so_oe) else $error("output driven while paused");
endmodule
bind sfph_protect_hold sfph_asserts chk_u (
  .core_clk(core_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .hold_n(hold_n),
  .wp_n(wp_n), .so_oe(so_oe), .quad_enable(quad_enable), .op_req(op_req),
  .protect_level(protect_level), .top_bottom_select(top_bottom_select),
  .status_write_lock(status_write_lock), .write_latch(write_latch), .otp_mode(otp_mode),
  .customer_otp_locked(customer_otp_locked), .protected_blocks(protected_blocks),
  .link_active(link_active));
`default_nettype wire

// >>> bench/sfph_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the link: mode 0, or idle-high clock with idle_hi set; outside frames the clock only steps back to its idle level
module sfph_host (
  output logic sclk,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input wire logic so_o,
  input wire logic so_oe
);
  logic [7:0] rx;
  logic oe_held;
  logic idle_hi = 1'b0; // Set for idle-high clock frames
  // Idle: deselected, no pause
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  // n bits out MSB first, rd answer bits in, pause over bit hb
  task automatic xfer(input logic [39:0] d, input int n, input int rd, input int hb);
    oe_held = 1'b0;
    cs_n = 1'b0;
    if (idle_hi) #62.5 sclk = 1'b0;
    for (int i = 0; i < n + rd; i++) begin
      si = (i < n) ? d[39 - i] : ~si;
      #62.5 sclk = 1'b1;
      rx = {rx[6:0], so_oe ? so_o : 1'bz};
      if (i == hb) begin
        hold_n = 1'b0;
        repeat (2) begin
          #62.5 sclk = 1'b0;
          si = ~si;
          #62.5 sclk = 1'b1;
          oe_held = oe_held | so_oe;
        end
        hold_n = 1'b1;
      end
      #62.5 sclk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    si = ~si; // Released line must not keep its last value
    #62.5 sclk = idle_hi; // Clock parks at its idle level only once deselected
    #500;
  endtask
endmodule
`default_nettype wire

// >>> bench/serial_flash_protect_hold_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module serial_flash_protect_hold_test
  import sfph_pkg::*;
;
  logic core_clk, reset_n, wp_n, quad_enable, factory_otp_locked, op_busy;
  logic sclk, cs_n, si, hold_n, so_o, so_oe, link_active, array_blocked;
  logic top_bottom_select, status_write_lock, write_latch, otp_mode, customer_otp_locked;
  logic [3:0] protect_level, protected_blocks;
  sfph_op_s op_req, last;
  int fails, tests_run, nreq, cycles;
  sfph_protect_hold dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .quad_enable(quad_enable),
    .factory_otp_locked(factory_otp_locked), .op_busy(op_busy), .op_req(op_req),
    .protect_level(protect_level), .top_bottom_select(top_bottom_select),
    .status_write_lock(status_write_lock), .write_latch(write_latch), .otp_mode(otp_mode),
    .customer_otp_locked(customer_otp_locked), .protected_blocks(protected_blocks),
    .array_blocked(array_blocked), .link_active(link_active));
  sfph_host host_u (.sclk(sclk), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_o(so_o),
    .so_oe(so_oe));
  always #20 core_clk = ~core_clk;
  // Count requests and keep the latest one
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (op_req.valid === 1'b1) begin
      nreq <= nreq + 1;
      last <= op_req;
    end
    if (cycles == 40000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] o, input logic [31:0] r, input int n);
    host_u.xfer({o, r}, n, 0, -1);
  endtask
  task automatic write_enable_cmd();
    send(OP_WR_EN, 32'h0, 8);
    `CHK(write_latch, 1'b1)
  endtask
  task automatic wrsr(input logic [3:0] l, input logic t, input logic k);
    write_enable_cmd();
    send(OP_WRSR, {k, 1'b0, l, 2'b00, 4'h0, t, 3'h0, 16'h0}, 24);
  endtask
  // Issue one command; expect a request of kind k, or none
  task automatic op_chk(input logic [7:0] o, input logic [23:0] a, input int n,
      input sfph_opk_e k);
    int n0;
    n0 = nreq;
    send(o, {a, 8'h5a}, n);
    `CHK(nreq - n0, (k == OPK_NONE) ? 0 : 1)
    if (k != OPK_NONE) `CHK(last.kind, k)
    if (k != OPK_NONE && k != OPK_CHIP) `CHK(last.addr, a)
  endtask
  initial begin
    logic [3:0] e;
    {core_clk, reset_n, quad_enable, factory_otp_locked, op_busy, wp_n} = 6'h01;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK({protect_level, top_bottom_select, status_write_lock, write_latch, otp_mode,
      customer_otp_locked}, 9'h0)
    host_u.xfer({OP_RDSR, 32'h0}, 8, 8, -1);
    `CHK(host_u.rx[0], 1'b0)
    for (int t = 0; t < 2; t++) begin
      for (int l = 0; l < 16; l++) begin
        e = (l == 0) ? 4'h0 : (l > 2) ? 4'hf : (t == 1) ? 4'((1 << l) - 1) :
          4'(4'hf << (4 - l));
        wrsr(l[3:0], t[0], 1'b0);
        `CHK(protect_level, l[3:0])
        `CHK(protected_blocks, e)
      end
    end
    $display("test protect map done");
    wrsr(4'h1, 1'b0, 1'b0);
    write_enable_cmd(); op_chk(OP_CE1, 24'h0, 8, OPK_NONE);
    write_enable_cmd(); op_chk(OP_SE, 24'h03f000, 32, OPK_NONE);
    write_enable_cmd(); op_chk(OP_BE, 24'h020000, 32, OPK_B64);
    wrsr(4'h0, 1'b0, 1'b0);
    write_enable_cmd(); op_chk(OP_CE2, 24'h0, 8, OPK_CHIP);
    op_chk(OP_SE, 24'h001000, 32, OPK_NONE);
    write_enable_cmd(); op_chk(OP_SE, 24'h040000, 32, OPK_NONE);
    write_enable_cmd(); op_chk(OP_PP, 24'h03ffff, 40, OPK_PROG);
    send(OP_WR_EN, 32'h0, 9);
    `CHK(write_latch, 1'b0)
    write_enable_cmd(); op_chk(OP_BE32, 24'h008000, 33, OPK_NONE);
    @(negedge core_clk) op_busy = 1'b1;
    write_enable_cmd(); op_chk(OP_SE, 24'h001000, 32, OPK_NONE);
    `CHK(array_blocked, 1'b1)
    @(negedge core_clk) op_busy = 1'b0;
    $display("test erase gating done");
    send(OP_OTP_ENTER, 32'h0, 8);
    `CHK({otp_mode, array_blocked}, 2'b11)
    write_enable_cmd(); op_chk(OP_SE, 24'h001000, 32, OPK_NONE);
    write_enable_cmd(); op_chk(OP_PP, 24'h000010, 40, OPK_OTP_PROG);
    write_enable_cmd(); send(OP_SEC_WR, 32'h0, 8);
    `CHK(customer_otp_locked, 1'b1)
    write_enable_cmd(); op_chk(OP_PP, 24'h000010, 40, OPK_NONE);
    write_enable_cmd(); op_chk(OP_PP, 24'h000210, 40, OPK_OTP_PROG);
    @(negedge core_clk) factory_otp_locked = 1'b1;
    write_enable_cmd(); op_chk(OP_PP, 24'h000210, 40, OPK_NONE);
    host_u.xfer({OP_SEC_RD, 32'h0}, 8, 16, -1);
    `CHK(host_u.rx[1:0], 2'b11)
    send(OP_OTP_EXIT, 32'h0, 8);
    `CHK(otp_mode, 1'b0)
    $display("test secured area done");
    wrsr(4'h5, 1'b1, 1'b1);
    host_u.xfer({OP_RDSR, 32'h0}, 8, 16, -1);
    `CHK(host_u.rx, 8'h94)
    @(negedge core_clk) wp_n = 1'b0;
    wrsr(4'h0, 1'b0, 1'b0);
    `CHK(protect_level, 4'h5)
    @(negedge core_clk) quad_enable = 1'b1;
    wrsr(4'h0, 1'b0, 1'b0);
    `CHK(protect_level, 4'h0)
    host_u.xfer({OP_WR_EN, 32'h0}, 8, 0, 3);
    `CHK(write_latch, 1'b0)
    @(negedge core_clk) {quad_enable, wp_n} = 2'b01;
    $display("test status protect done");
    host_u.xfer({8'hff, 32'h0}, 8, 8, -1);
    `CHK(host_u.rx, 8'hzz)
    host_u.xfer({OP_RDSR, 32'h0}, 8, 5, 10);
    `CHK(host_u.oe_held, 1'b0)
    host_u.xfer({OP_WR_EN, 32'h0}, 8, 0, 3);
    `CHK(write_latch, 1'b1)
    $display("test link pause done");
    host_u.idle_hi = 1'b1;
    send(OP_WRDI, 32'h0, 8);
    host_u.xfer({OP_RDSR, 32'h0}, 8, 8, -1);
    `CHK(host_u.rx, 8'h00)
    $display("test clock idle high done");
    report_and_stop();
  end
endmodule
`default_nettype wire
